// file: verilog/rtcal_pkg.sv
// Purpose: Shared constants and carriers for the RTC alarm block
// Assumes: Registers on a 32-bit AHB-Lite slave, word accesses only
// Notes:   Field positions are bit indices inside the 32-bit word
package rtcal_pkg;

	// Register byte offsets inside the block window
	localparam int unsigned OFS_W    = 8;
	localparam logic [7:0]  OFS_CTRL = 8'h00;
	localparam logic [7:0]  OFS_DATE = 8'h04;
	localparam logic [7:0]  OFS_TIME = 8'h08;

	// Alarm control word layout
	localparam int unsigned CTL_ARM      = 15;
	localparam int unsigned CTL_CHIME    = 14;
	localparam int unsigned CTL_PIV      = 13;
	localparam int unsigned CTL_NEAR     = 12;
	localparam int unsigned CTL_MASK_LSB = 8;
	localparam int unsigned CTL_RPT_LSB  = 0;
	localparam int unsigned MASK_W       = 4;
	localparam int unsigned RPT_W        = 8;
	localparam logic [7:0]  RPT_ZERO     = 8'h00;
	localparam logic [7:0]  RPT_FULL     = 8'hFF;
	localparam logic [7:0]  RPT_ONE      = 8'h01;

	// Alarm date word layout
	localparam int unsigned DT_MON_T     = 20;
	localparam int unsigned DT_MON_O_LSB = 16;
	localparam int unsigned DT_DAY_T_LSB = 12;
	localparam int unsigned DT_DAY_O_LSB = 8;
	localparam int unsigned DT_WDAY_LSB  = 0;

	// Alarm time word layout
	localparam int unsigned TM_HR_T_LSB  = 28;
	localparam int unsigned TM_HR_O_LSB  = 24;
	localparam int unsigned TM_MIN_T_LSB = 20;
	localparam int unsigned TM_MIN_O_LSB = 16;
	localparam int unsigned TM_SEC_T_LSB = 12;
	localparam int unsigned TM_SEC_O_LSB = 8;

	// Interval select codes
	localparam logic [3:0] MASK_HALF  = 4'h0;
	localparam logic [3:0] MASK_SEC   = 4'h1;
	localparam logic [3:0] MASK_SEC10 = 4'h2;
	localparam logic [3:0] MASK_MIN   = 4'h3;
	localparam logic [3:0] MASK_MIN10 = 4'h4;
	localparam logic [3:0] MASK_HOUR  = 4'h5;
	localparam logic [3:0] MASK_DAY   = 4'h6;
	localparam logic [3:0] MASK_WEEK  = 4'h7;
	localparam logic [3:0] MASK_MONTH = 4'h8;
	localparam logic [3:0] MASK_YEAR  = 4'h9;

	// Leap day in BCD
	localparam logic       FEB_MON_T  = 1'h0;
	localparam logic [3:0] FEB_MON_O  = 4'h2;
	localparam logic [1:0] LEAP_DAY_T = 2'h2;
	localparam logic [3:0] LEAP_DAY_O = 4'h9;

	// Prescaler counts 0..PRESC_LAST between half-second rollovers
	localparam int unsigned PRESC_W       = 15;
	localparam logic [14:0] PRESC_LAST    = 15'h3FFF;
	localparam int unsigned NEAR_RTC_CLKS = 32;
	localparam logic [14:0] NEAR_START    =
		15'(int'(PRESC_LAST) + 1 - NEAR_RTC_CLKS);

	// AHB-Lite encodings
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic       HRESP_OKAY = 1'h0;

	// Alarm compare value, BCD digits
	typedef struct packed {
		logic       month_tens;
		logic [3:0] month_ones;
		logic [1:0] day_tens;
		logic [3:0] day_ones;
		logic [2:0] weekday_digit;
		logic [1:0] hour_tens;
		logic [3:0] hour_ones;
		logic [2:0] min_tens;
		logic [3:0] min_ones;
		logic [2:0] sec_tens;
		logic [3:0] sec_ones;
	} rtcal_stamp_s;

	// Running time from the RTC counters
	typedef struct packed {
		logic [3:0]   year_tens;
		logic [3:0]   year_ones;
		logic         half;
		rtcal_stamp_s stamp;
	} rtcal_time_s;

endpackage

// file: verilog/rtcal_match.sv
// Purpose: Compare alarm value with running time under interval select
// Assumes: Time fields are valid BCD in the cycle of the rollover tick
// Notes:   Purely combinational; the caller qualifies with the tick
`timescale 1ns/100ps
module rtcal_match
	import rtcal_pkg::*;
(
	input  wire rtcal_time_s        now,
	input  wire rtcal_stamp_s       alm,
	input  wire logic [MASK_W-1:0]  mask,
	output logic                    hit
);

	logic full_sec;
	logic sec_o_eq;
	logic sec_eq;
	logic min_o_eq;
	logic min_eq;
	logic hr_eq;
	logic wd_eq;
	logic day_eq;
	logic mon_eq;
	logic leap_day;
	logic leap_ok;

	// Field compares; half=0 marks the start of a whole second
	assign full_sec = ~now.half;
	assign sec_o_eq = now.stamp.sec_ones == alm.sec_ones;
	assign sec_eq   = sec_o_eq && now.stamp.sec_tens == alm.sec_tens;
	assign min_o_eq = now.stamp.min_ones == alm.min_ones;
	assign min_eq   = min_o_eq && now.stamp.min_tens == alm.min_tens;
	assign hr_eq    = now.stamp.hour_ones == alm.hour_ones &&
		now.stamp.hour_tens == alm.hour_tens;
	assign wd_eq    = now.stamp.weekday_digit == alm.weekday_digit;
	assign day_eq   = now.stamp.day_ones == alm.day_ones &&
		now.stamp.day_tens == alm.day_tens;
	assign mon_eq   = now.stamp.month_ones == alm.month_ones &&
		now.stamp.month_tens == alm.month_tens;

	// Year divisible by four: (2*tens + ones) mod 4 == 0 in BCD
	assign leap_day = alm.month_tens == FEB_MON_T &&
		alm.month_ones == FEB_MON_O && alm.day_tens == LEAP_DAY_T &&
		alm.day_ones == LEAP_DAY_O;
	assign leap_ok  = ~leap_day ||
		(~(now.year_ones[1] ^ now.year_tens[0]) & ~now.year_ones[0]);

	// Interval select; reserved codes never match
	always_comb begin
		unique case (mask)
			MASK_HALF:  hit = 1'b1;
			MASK_SEC:   hit = full_sec;
			MASK_SEC10: hit = full_sec && sec_o_eq;
			MASK_MIN:   hit = full_sec && sec_eq;
			MASK_MIN10: hit = full_sec && sec_eq && min_o_eq;
			MASK_HOUR:  hit = full_sec && sec_eq && min_eq;
			MASK_DAY:   hit = full_sec && sec_eq && min_eq && hr_eq;
			MASK_WEEK:  hit = full_sec && sec_eq && min_eq && hr_eq &&
				wd_eq;
			MASK_MONTH: hit = full_sec && sec_eq && min_eq && hr_eq &&
				day_eq;
			MASK_YEAR:  hit = full_sec && sec_eq && min_eq && hr_eq &&
				day_eq && mon_eq && leap_ok;
			default:    hit = 1'b0;
		endcase
	end

endmodule

// file: verilog/rtcal_alarm.sv
// Purpose: RTC alarm control, repeat counter and alarm pulse
// Assumes: RTC time, tick and prescaler come from logic on hclk
// Notes:   hresetn is the power-on reset; no other reset reaches here
// Function
// - Last alarm without chime clears arm bit
// - Chime wraps repeat count 00 to FF
// - Without chime repeat count stops at zero
// - Each alarm event decrements a nonzero repeat count
// - Count plus one equals total alarm triggers
// - Disarmed: start level writable, sets pulse level
// - Armed: start level ignores writes, reads pulse
// - Rollover flag set within 32 clocks
// - Interval select picks alarm period
// - Feb 29 yearly alarm fires every four years
// - Alarm registers cleared only by power-on
// - Date register holds month and day BCD
// - Date register low bits hold weekday
//
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
module rtcal_alarm
	import rtcal_pkg::*;
(
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic                     hreadyout,
	output logic                     hresp,
	output logic [31:0]              hrdata,
	input  wire logic                rtc_tick,
	input  wire rtcal_time_s         rtc_now,
	input  wire logic [PRESC_W-1:0]  rtc_presc,
	output logic                     alarm_pulse,
	output logic                     alarm_event
);

	// Whole block state, registered in one place
	typedef struct packed {
		logic              alarm_arm;
		logic              chime;
		logic              pulse_start_level;
		logic              pulse;
		logic              rollover_near_flag;
		logic [MASK_W-1:0] match_interval_select;
		logic [RPT_W-1:0]  repeat_count;
		rtcal_stamp_s      alarm;
		logic              evt;
		logic              wr_pend;
		logic [OFS_W-1:0]  wr_ofs;
		logic [31:0]       rdata;
	} rtcal_state_s;

	rtcal_state_s st_r;
	rtcal_state_s st_nxt;
	logic         hit;
	logic         fire;
	logic         accept;
	logic         ctrl_wr;
	logic         date_wr;
	logic         time_wr;

	// Read word for one offset; unmapped offsets read zero
	function automatic logic [31:0] rd_word(
		input logic [OFS_W-1:0] ofs,
		input rtcal_state_s     s
	);
		logic [31:0] w;
		w = 32'h0000_0000;
		unique case (ofs)
			OFS_CTRL: begin
				w[CTL_ARM]   = s.alarm_arm;
				w[CTL_CHIME] = s.chime;
				// Armed: live pulse level, else stored start level
				w[CTL_PIV]   = s.alarm_arm ? s.pulse :
					s.pulse_start_level;
				w[CTL_NEAR]  = s.rollover_near_flag;
				w[CTL_MASK_LSB +: MASK_W] = s.match_interval_select;
				w[CTL_RPT_LSB +: RPT_W]   = s.repeat_count;
			end
			OFS_DATE: begin
				w[DT_MON_T]            = s.alarm.month_tens;
				w[DT_MON_O_LSB +: 4]   = s.alarm.month_ones;
				w[DT_DAY_T_LSB +: 2]   = s.alarm.day_tens;
				w[DT_DAY_O_LSB +: 4]   = s.alarm.day_ones;
				w[DT_WDAY_LSB +: 3]    = s.alarm.weekday_digit;
			end
			OFS_TIME: begin
				w[TM_HR_T_LSB +: 2]  = s.alarm.hour_tens;
				w[TM_HR_O_LSB +: 4]  = s.alarm.hour_ones;
				w[TM_MIN_T_LSB +: 3] = s.alarm.min_tens;
				w[TM_MIN_O_LSB +: 4] = s.alarm.min_ones;
				w[TM_SEC_T_LSB +: 3] = s.alarm.sec_tens;
				w[TM_SEC_O_LSB +: 4] = s.alarm.sec_ones;
			end
			default: w = 32'h0000_0000;
		endcase
		return w;
	endfunction

	// Field compare against the running time
	rtcal_match u_match (
		.now  (rtc_now),
		.alm  (st_r.alarm),
		.mask (st_r.match_interval_select),
		.hit  (hit)
	);

	// Bus decode: data phase writes, address phase accepts
	assign accept  = hsel && hready && htrans[1];
	assign ctrl_wr = st_r.wr_pend && st_r.wr_ofs == OFS_CTRL;
	assign date_wr = st_r.wr_pend && st_r.wr_ofs == OFS_DATE;
	assign time_wr = st_r.wr_pend && st_r.wr_ofs == OFS_TIME;
	// Events only land on half-second ticks of an armed alarm
	assign fire    = rtc_tick && st_r.alarm_arm && hit;

	// Next-state logic
	always_comb begin
		st_nxt     = st_r;
		st_nxt.evt = 1'b0;

		// Alarm event: toggle pulse and step the repeat counter
		if (fire) begin
			st_nxt.evt   = 1'b1;
			st_nxt.pulse = ~st_r.pulse;
			if (st_r.repeat_count == RPT_ZERO) begin
				if (st_r.chime) begin
					st_nxt.repeat_count = RPT_FULL;
				end else begin
					// Count held at zero, last trigger disarms
					st_nxt.alarm_arm = 1'b0;
				end
			end else begin
				st_nxt.repeat_count = st_r.repeat_count - RPT_ONE;
			end
		end

		// Software write lands after the event, so it wins the cycle
		if (ctrl_wr) begin
			st_nxt.alarm_arm = hwdata[CTL_ARM];
			st_nxt.chime     = hwdata[CTL_CHIME];
			st_nxt.match_interval_select =
				hwdata[CTL_MASK_LSB +: MASK_W];
			st_nxt.repeat_count = hwdata[CTL_RPT_LSB +: RPT_W];
			if (!st_r.alarm_arm) begin
				st_nxt.pulse_start_level = hwdata[CTL_PIV];
			end
		end
		if (date_wr) begin
			st_nxt.alarm.month_tens    = hwdata[DT_MON_T];
			st_nxt.alarm.month_ones    = hwdata[DT_MON_O_LSB +: 4];
			st_nxt.alarm.day_tens      = hwdata[DT_DAY_T_LSB +: 2];
			st_nxt.alarm.day_ones      = hwdata[DT_DAY_O_LSB +: 4];
			st_nxt.alarm.weekday_digit = hwdata[DT_WDAY_LSB +: 3];
		end
		if (time_wr) begin
			st_nxt.alarm.hour_tens = hwdata[TM_HR_T_LSB +: 2];
			st_nxt.alarm.hour_ones = hwdata[TM_HR_O_LSB +: 4];
			st_nxt.alarm.min_tens  = hwdata[TM_MIN_T_LSB +: 3];
			st_nxt.alarm.min_ones  = hwdata[TM_MIN_O_LSB +: 4];
			st_nxt.alarm.sec_tens  = hwdata[TM_SEC_T_LSB +: 3];
			st_nxt.alarm.sec_ones  = hwdata[TM_SEC_O_LSB +: 4];
		end

		// Keep start level equal to the pulse when leaving armed,
		// so disarming never makes the output jump
		if (st_r.alarm_arm && !st_nxt.alarm_arm) begin
			st_nxt.pulse_start_level = st_nxt.pulse;
		end
		if (!st_r.alarm_arm) begin
			st_nxt.pulse = st_nxt.pulse_start_level;
		end

		// Near-rollover warning from the prescaler position
		st_nxt.rollover_near_flag = rtc_presc >= NEAR_START;

		// Address phase capture; read data staged for data phase
		st_nxt.wr_pend = accept && hwrite && hsize == HSIZE_WORD;
		st_nxt.wr_ofs  = haddr[OFS_W-1:0];
		if (accept && !hwrite) begin
			st_nxt.rdata = rd_word(haddr[OFS_W-1:0], st_r);
		end
	end

	// Only the power-on reset clears the alarm registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs; zero wait states, always OKAY
	assign hreadyout   = 1'b1;
	assign hresp       = HRESP_OKAY;
	assign hrdata      = st_r.rdata;
	assign alarm_pulse = st_r.pulse;
	assign alarm_event = st_r.evt;

	// Helper terms for the checks below
	logic leap_now;
	logic feb29;
	assign leap_now = ~(rtc_now.year_ones[1] ^ rtc_now.year_tens[0]) &
		~rtc_now.year_ones[0];
	assign feb29 = st_r.alarm.month_ones == FEB_MON_O &&
		st_r.alarm.month_tens == FEB_MON_T &&
		st_r.alarm.day_tens == LEAP_DAY_T &&
		st_r.alarm.day_ones == LEAP_DAY_O;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// Last trigger without chime disarms and leaves the count at zero
	AST_DISARM_LAST: assert property (
		fire && st_r.repeat_count == RPT_ZERO && !st_r.chime &&
		!ctrl_wr |=> !st_r.alarm_arm && alarm_event &&
		st_r.repeat_count == RPT_ZERO)
		else $error("arm not cleared after last alarm");

	// Chime wraps the counter to all ones
	AST_CHIME_WRAP: assert property (
		fire && st_r.repeat_count == RPT_ZERO && st_r.chime &&
		!ctrl_wr |=> st_r.repeat_count == RPT_FULL && st_r.alarm_arm)
		else $error("chime did not wrap repeat count");

	// Without chime a zero count never wraps
	AST_NO_WRAP: assert property (
		st_r.repeat_count == RPT_ZERO && !st_r.chime && !ctrl_wr
		|=> st_r.repeat_count == RPT_ZERO)
		else $error("repeat count left zero without chime");

	// Each event steps a nonzero count down by one
	AST_DECREMENT: assert property (
		fire && st_r.repeat_count != RPT_ZERO && !ctrl_wr
		|=> st_r.repeat_count == $past(st_r.repeat_count) - RPT_ONE)
		else $error("repeat count not decremented");

	// Count changes only through an event or a control write
	AST_COUNT_CAUSE: assert property (
		!fire && !ctrl_wr |=> $stable(st_r.repeat_count))
		else $error("repeat count changed without cause");

	// Disarmed output sits at the start level
	AST_PIV_LEVEL: assert property (
		!st_r.alarm_arm |-> st_r.pulse == st_r.pulse_start_level)
		else $error("disarmed pulse differs from start level");

	// Armed output moves only on events
	AST_PIV_LOCK: assert property (
		st_r.alarm_arm && !fire ##1 st_r.alarm_arm
		|-> $stable(alarm_pulse))
		else $error("armed pulse moved without event");

	// Flag follows the prescaler window one cycle later
	AST_NEAR_FLAG: assert property (
		##1 st_r.rollover_near_flag ==
		($past(rtc_presc) >= NEAR_START))
		else $error("rollover flag wrong for prescaler");

	// Reserved interval codes never raise an event
	AST_RESERVED: assert property (
		st_r.match_interval_select > MASK_YEAR |=> !alarm_event)
		else $error("event on reserved interval code");

	// Feb 29 yearly alarm fires only in leap years
	AST_LEAP_ONLY: assert property (
		fire && st_r.match_interval_select == MASK_YEAR && feb29
		|-> leap_now)
		else $error("feb 29 alarm outside a leap year");

	// Event needs an armed alarm and a tick
	AST_EVENT_CAUSE: assert property (
		alarm_event |-> $past(st_r.alarm_arm) && $past(rtc_tick))
		else $error("event without armed tick");

	// Output toggles with every event
	AST_TOGGLE: assert property (
		alarm_event |-> alarm_pulse != $past(alarm_pulse))
		else $error("pulse did not toggle on event");

	// Arm bit drops only on a write or the last trigger
	AST_ARM_HOLD: assert property (
		st_r.alarm_arm && !ctrl_wr && !(fire && !st_r.chime &&
		st_r.repeat_count == RPT_ZERO) |=> st_r.alarm_arm)
		else $error("arm bit dropped without cause");

	// Disarmed write sets start level and output together
	AST_PIV_OPEN: assert property (
		ctrl_wr && !st_r.alarm_arm |=> alarm_pulse == $past(hwdata[CTL_PIV])
		&& st_r.pulse_start_level == $past(hwdata[CTL_PIV]))
		else $error("start level write not taken");

	// Armed write that stays armed leaves the start level alone
	AST_PIV_SHUT: assert property (
		ctrl_wr && st_r.alarm_arm && hwdata[CTL_ARM]
		|=> $stable(st_r.pulse_start_level))
		else $error("start level changed while armed");

	// Control read carries the registered rollover flag
	AST_RD_NEAR: assert property (
		accept && !hwrite && haddr[OFS_W-1:0] == OFS_CTRL
		|=> hrdata[CTL_NEAR] == $past(st_r.rollover_near_flag))
		else $error("read flag differs from rollover flag");

	// Only the half-second code fires on a mid-second tick
	AST_WHOLE_SEC: assert property (
		fire && st_r.match_interval_select != MASK_HALF
		|-> !rtc_now.half)
		else $error("event on mid-second tick");

	// Date write lands in the day digits
	AST_DATE_WR: assert property (
		date_wr |=> st_r.alarm.day_ones == $past(hwdata[DT_DAY_O_LSB +: 4])
		&& st_r.alarm.day_tens == $past(hwdata[DT_DAY_T_LSB +: 2]))
		else $error("date digits not written");

	// Date write lands in the weekday digit
	AST_WDAY_WR: assert property (
		date_wr |=> st_r.alarm.weekday_digit ==
		$past(hwdata[DT_WDAY_LSB +: 3]))
		else $error("weekday digit not written");

	// Main scenarios
	COV_WRAP: cover property (
		fire && st_r.chime && st_r.repeat_count == RPT_ZERO);
	COV_LAST: cover property (
		fire && !st_r.chime && st_r.repeat_count == RPT_ZERO);
	COV_NEAR_READ: cover property (
		accept && !hwrite && st_r.rollover_near_flag);
	COV_YEAR: cover property (
		fire && st_r.match_interval_select == MASK_YEAR);

endmodule

// file: testbench/rtc_alarm_repeat_logic_test.sv
// Purpose: Self-checking bench for the RTC alarm block over AHB-Lite
// Assumes: One slave, so hready is the slave's own hreadyout
// Notes:   Matches use zero time except the leap-day and seconds compare scenarios
`timescale 1ns/100ps
module rtc_alarm_repeat_logic_test
	import rtcal_pkg::*;
;
	logic                hclk;
	logic                hresetn;
	logic                hsel;
	logic [31:0]         haddr;
	logic [1:0]          htrans;
	logic                hwrite;
	logic [2:0]          hsize;
	logic [31:0]         hwdata;
	logic                hready;
	logic                hresp;
	logic [31:0]         hrdata;
	logic                rtc_tick;
	rtcal_time_s         rtc_now;
	logic [PRESC_W-1:0]  rtc_presc;
	logic                alarm_pulse;
	logic                alarm_event;
	int                  n_errors;
	int                  total_checks;

	rtcal_alarm dut (
		.hclk        (hclk),
		.hresetn     (hresetn),
		.hsel        (hsel),
		.haddr       (haddr),
		.htrans      (htrans),
		.hwrite      (hwrite),
		.hsize       (hsize),
		.hwdata      (hwdata),
		.hready      (hready),
		.hreadyout   (hready),
		.hresp       (hresp),
		.hrdata      (hrdata),
		.rtc_tick    (rtc_tick),
		.rtc_now     (rtc_now),
		.rtc_presc   (rtc_presc),
		.alarm_pulse (alarm_pulse),
		.alarm_event (alarm_event)
	);

	// Free-running bus clock, 4 ns period
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One single word transfer; waits for hready in each phase
	task automatic bus(input logic wr, input logic [31:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		int n;
		@(posedge hclk);
		htrans <= 2'b10;
		haddr  <= a;
		hwrite <= wr;
		hsize  <= HSIZE_WORD;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1);
		// No wait states: the address phase ends at the first edge
		chk("addr waits", 32'(n), 32'h0000_0001);
		htrans <= 2'b00;
		if (wr) begin
			hwdata <= wd;
		end
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1);
		rd = hrdata;
		chk("hresp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
		chk("data waits", 32'(n), 32'h0000_0001);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		bus(1'b1, a, d, dummy);
	endtask

	task automatic rd_chk(input string nm, input logic [31:0] a,
		input logic [31:0] exp);
		logic [31:0] d;
		bus(1'b0, a, 32'h0000_0000, d);
		chk(nm, d, exp);
	endtask

	// Half-second tick with a given time; event must follow one cycle on
	task automatic tick(input rtcal_time_s t, input logic ev);
		@(posedge hclk);
		rtc_now  <= t;
		rtc_tick <= 1'b1;
		@(posedge hclk);
		rtc_tick <= 1'b0;
		#1 chk("alarm_event", {31'h0, alarm_event}, {31'h0, ev});
		@(posedge hclk);
		#1 chk("event width", {31'h0, alarm_event}, 32'h0000_0000);
	endtask

	// Reset values and an unmapped place
	task automatic t_reset_regs();
		rd_chk("ctrl rst", 32'h0000_0000, 32'h0000_0000);
		rd_chk("date rst", 32'h0000_0004, 32'h0000_0000);
		wr(32'h0000_0010, 32'hFFFF_FFFF);
		rd_chk("unmapped", 32'h0000_0010, 32'h0000_0000);
		wr(32'h0000_0004, 32'hFFFF_FFFF);
		rd_chk("date bits", 32'h0000_0004, 32'h001F_3F07);
		wr(32'h0000_0004, 32'h0012_3106);
		rd_chk("date val", 32'h0000_0004, 32'h0012_3106);
		wr(32'h0000_0004, 32'h0000_0000);
	endtask

	// Count of two gives three alarms, then the arm bit drops
	task automatic t_repeat();
		rtcal_time_s t;
		t = '0;
		wr(32'h0000_0000, 32'h0000_8002);
		tick(t, 1'b1);
		chk("pulse 1", {31'h0, alarm_pulse}, 32'h0000_0001);
		tick(t, 1'b1);
		chk("pulse 2", {31'h0, alarm_pulse}, 32'h0000_0000);
		tick(t, 1'b1);
		chk("pulse 3", {31'h0, alarm_pulse}, 32'h0000_0001);
		rd_chk("ctrl end", 32'h0000_0000, 32'h0000_2000);
		tick(t, 1'b0);
		chk("pulse held", {31'h0, alarm_pulse}, 32'h0000_0001);
	endtask

	// Chime wraps the count and keeps the alarm armed
	task automatic t_chime();
		rtcal_time_s t;
		logic [31:0] d;
		t = '0;
		wr(32'h0000_0000, 32'h0000_C000);
		tick(t, 1'b1);
		bus(1'b0, 32'h0000_0000, 32'h0000_0000, d);
		chk("chime wrap", d & 32'h0000_DFFF, 32'h0000_C0FF);
		tick(t, 1'b1);
		bus(1'b0, 32'h0000_0000, 32'h0000_0000, d);
		chk("chime dec", d & 32'h0000_DFFF, 32'h0000_C0FE);
		wr(32'h0000_0000, 32'h0000_0000);
	endtask

	// Start level writable only while disarmed
	task automatic t_start_level();
		rtcal_time_s t;
		t = '0;
		wr(32'h0000_0000, 32'h0000_2000);
		rd_chk("piv set", 32'h0000_0000, 32'h0000_2000);
		chk("pulse start", {31'h0, alarm_pulse}, 32'h0000_0001);
		wr(32'h0000_0000, 32'h0000_A003);
		wr(32'h0000_0000, 32'h0000_8003);
		rd_chk("piv locked", 32'h0000_0000, 32'h0000_A003);
		tick(t, 1'b1);
		chk("pulse tgl", {31'h0, alarm_pulse}, 32'h0000_0000);
		rd_chk("piv live", 32'h0000_0000, 32'h0000_8002);
		wr(32'h0000_0000, 32'h0000_0000);
	endtask

	// Rollover-near flag around the last 32 prescaler counts
	task automatic t_near();
		logic [14:0] p [4];
		logic        f [4];
		p = '{NEAR_START - 15'h0001, NEAR_START, PRESC_LAST, 15'h0000};
		f = '{1'b0, 1'b1, 1'b1, 1'b0};
		// No writes here, so none lands inside the warning window
		for (int i = 0; i < 4; i++) begin
			@(posedge hclk);
			rtc_presc <= p[i];
			repeat (2) @(posedge hclk);
			rd_chk("near flag", 32'h0000_0000, 32'(f[i]) << 12);
			rd_chk("near again", 32'h0000_0000, 32'(f[i]) << 12);
		end
	endtask

	// Every interval code, then reserved codes stay silent
	task automatic t_intervals();
		rtcal_time_s t;
		rtcal_time_s th;
		t = '0;
		th = '0;
		th.half = 1'b1;
		for (int k = 0; k < 10; k++) begin
			wr(32'h0000_0000, 32'h0000_C080 | (32'(k) << 8));
			tick(t, 1'b1);
			if (k > 0) begin
				tick(th, 1'b0);
			end
		end
		wr(32'h0000_0000, 32'h0000_CA80);
		tick(t, 1'b0);
		wr(32'h0000_0000, 32'h0000_CF80);
		tick(t, 1'b0);
		// Leap-day yearly alarm only in years divisible by four
		wr(32'h0000_0004, 32'h0002_2900);
		wr(32'h0000_0000, 32'h0000_C980);
		t.stamp.month_ones = FEB_MON_O;
		t.stamp.day_tens = LEAP_DAY_T;
		t.stamp.day_ones = LEAP_DAY_O;
		t.year_tens = 4'h2;
		t.year_ones = 4'h3;
		tick(t, 1'b0);
		t.year_ones = 4'h4;
		tick(t, 1'b1);
		wr(32'h0000_0000, 32'h0000_0000);
		wr(32'h0000_0004, 32'h0000_0000);
	endtask

	// Alarm time register, then a seconds compare under minute select
	task automatic t_time();
		rtcal_time_s t;
		t = '0;
		wr(32'h0000_0008, 32'hFFFF_FFFF);
		rd_chk("time bits", 32'h0000_0008, 32'h3F7F_7F00);
		wr(32'h0000_0008, 32'h0000_3000);
		wr(32'h0000_0000, 32'h0000_C380);
		tick(t, 1'b0);
		t.stamp.sec_tens = 3'h3;
		tick(t, 1'b1);
		wr(32'h0000_0000, 32'h0000_0000);
		wr(32'h0000_0008, 32'h0000_0000);
	endtask

	// Power-on reset in mid-run clears the control word
	task automatic t_por();
		wr(32'h0000_0000, 32'h0000_2055);
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rd_chk("ctrl por", 32'h0000_0000, 32'h0000_0000);
		chk("pulse por", {31'h0, alarm_pulse}, 32'h0000_0000);
	endtask

	// Main sequence
	initial begin
		n_errors = 0;
		total_checks = 0;
		hresetn = 1'b0;
		hsel = 1'b1;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = HSIZE_WORD;
		hwdata = 32'h0000_0000;
		rtc_tick = 1'b0;
		rtc_now = '0;
		rtc_presc = 15'h0000;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset_regs();
		t_repeat();
		t_chime();
		t_start_level();
		t_near();
		t_intervals();
		t_time();
		t_por();
		conclude();
	end

	// Watchdog, well past the few hundred cycles the tests need
	initial begin
		#80000;
		n_errors++;
		conclude();
	end
endmodule
